// File: logic/tcfc_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - mode register resets to 0x1006
// - bit 1 applies maker scaling, tenth degree
// - code 1111 unscaled gives sixteenth degree digits
// - code 1111 maker scaled gives tenth degree
// - bit 2 enables watchdog, set by default
// - bit 3 selects sign-magnitude output
// - bit 4 puts status in low bits
// - tagged value in bits 15..3
// - tagged bit 0 flags out of range
// - bit 5 enables filter constant timing
// - bit 6 turns off open-circuit current
// - bit 8 turns off cold-junction compensation
// - bit 10 skips lower range check
// - bits 15..12 select element type
// - codes 1101..1111 select voltage ranges
// - user scaling uses signed offset, gain/256
// - filter constant maps to notch and time
// - parameter writes need unlock key held
module tcfc_top #(
	parameter int CLK_HZ = 100_000_000
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        reg_req,
	input  wire logic        reg_write,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output var  logic [15:0] reg_rdata,
	output var  logic        reg_ack,
	input  wire logic [15:0] adc_value,
	input  wire logic        adc_strobe,
	output var  logic [15:0] process_word,
	output var  logic        process_valid,
	output var  logic        over_range,
	output var  logic        watchdog_en,
	output var  logic        open_circuit_current_en,
	output var  logic        cold_junction_en,
	output var  logic [3:0]  element_type,
	output var  logic        conversion_tick,
	output var  logic [15:0] notch_dhz
);
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int CONV_MAX = tcfc_pkg::CONV_MS_12HZ5 * CYC_PER_MS;

	// the longest period must fit the 32-bit conversion counter
	if (CLK_HZ < 1000 || CLK_HZ > 1_000_000_000 || CONV_MAX <= 0) begin : g_bad_clk
		$error("core clock outside 1 kHz to 1 GHz cannot time conversions");
	end

	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] usr_offset;
		logic [15:0] usr_gain;
		logic [15:0] filter;
		logic [15:0] key;
		logic [15:0] rdata;
		logic        ack;
		logic [15:0] adc_s1;
		logic [15:0] adc_s2;
		logic [2:0]  stb_sync;
		logic [15:0] raw;
		logic        raw_valid;
		logic [31:0] conv_cnt;
		logic        tick;
		logic [15:0] notch;
	} tcfc_state_t;

	tcfc_state_t state;
	tcfc_state_t next_state;
	tcfc_scale_if sif ();

	// ----------------------------------------
	// filter constant to conversion period
	// ----------------------------------------
	function automatic logic [31:0] conv_cycles(input logic [15:0] fc, input logic en);
		logic [31:0] ms;
		ms = 32'(tcfc_pkg::CONV_MS_25HZ);
		if (en) begin
			unique case (fc)
				tcfc_pkg::FC_100HZ: ms = 32'(tcfc_pkg::CONV_MS_100HZ);
				tcfc_pkg::FC_50HZ:  ms = 32'(tcfc_pkg::CONV_MS_50HZ);
				tcfc_pkg::FC_12HZ5: ms = 32'(tcfc_pkg::CONV_MS_12HZ5);
				default:            ms = 32'(tcfc_pkg::CONV_MS_25HZ);
			endcase
		end
		conv_cycles = ms * 32'(CYC_PER_MS);
	endfunction

	function automatic logic [15:0] notch_of(input logic [15:0] fc, input logic en);
		notch_of = 16'(tcfc_pkg::NOTCH_DHZ_25);
		if (en) begin
			unique case (fc)
				tcfc_pkg::FC_100HZ: notch_of = 16'(tcfc_pkg::NOTCH_DHZ_100);
				tcfc_pkg::FC_50HZ:  notch_of = 16'(tcfc_pkg::NOTCH_DHZ_50);
				tcfc_pkg::FC_12HZ5: notch_of = 16'(tcfc_pkg::NOTCH_DHZ_12);
				default:            notch_of = 16'(tcfc_pkg::NOTCH_DHZ_25);
			endcase
		end
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic unlocked;
		unlocked = (state.key == tcfc_pkg::UNLOCK_KEY);
		next_state = state;
		next_state.ack = 1'b0;
		// register port
		if (reg_req) begin
			next_state.ack = 1'b1;
			if (reg_write) begin
				if (reg_addr == tcfc_pkg::ADDR_UNLOCK_KEY) begin
					next_state.key = reg_wdata;
				end else if (unlocked) begin
					unique case (reg_addr)
						tcfc_pkg::ADDR_MODE_CFG:   next_state.mode = reg_wdata;
						tcfc_pkg::ADDR_USR_OFFSET: next_state.usr_offset = reg_wdata;
						tcfc_pkg::ADDR_USR_GAIN:   next_state.usr_gain = reg_wdata;
						tcfc_pkg::ADDR_FILTER:     next_state.filter = reg_wdata;
						default: ;
					endcase
				end
			end
			unique case (reg_addr)
				// key reads back only while unlocked
				tcfc_pkg::ADDR_UNLOCK_KEY: next_state.rdata = unlocked ? state.key : '0;
				tcfc_pkg::ADDR_MODE_CFG:   next_state.rdata = state.mode;
				tcfc_pkg::ADDR_USR_OFFSET: next_state.rdata = state.usr_offset;
				tcfc_pkg::ADDR_USR_GAIN:   next_state.rdata = state.usr_gain;
				tcfc_pkg::ADDR_FILTER:     next_state.rdata = state.filter;
				default:                   next_state.rdata = '0;
			endcase
		end
		// adc input crosses in through two stages before use
		next_state.adc_s1 = adc_value;
		next_state.adc_s2 = state.adc_s1;
		next_state.stb_sync = {state.stb_sync[1:0], adc_strobe};
		next_state.raw_valid = state.stb_sync[1] && !state.stb_sync[2];
		if (next_state.raw_valid) begin
			next_state.raw = state.adc_s2;
		end
		// conversion pacing
		next_state.tick = 1'b0;
		if (state.conv_cnt + 32'h1 >= conv_cycles(state.filter,
			state.mode[tcfc_pkg::BIT_FILTER_EN])) begin
			next_state.conv_cnt = '0;
			next_state.tick = 1'b1;
		end else begin
			next_state.conv_cnt = state.conv_cnt + 32'h1;
		end
		next_state.notch = notch_of(state.filter, state.mode[tcfc_pkg::BIT_FILTER_EN]);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
			state.mode <= tcfc_pkg::MODE_CFG_RESET;
			state.usr_offset <= tcfc_pkg::USR_OFFSET_RST;
			state.usr_gain <= tcfc_pkg::USR_GAIN_RST;
			state.filter <= tcfc_pkg::FILTER_RESET;
			state.notch <= 16'(tcfc_pkg::NOTCH_DHZ_25);
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// formatting stage
	// ----------------------------------------
	assign sif.mode = state.mode;
	assign sif.usr_offset = state.usr_offset;
	assign sif.usr_gain = state.usr_gain;
	assign sif.raw = state.raw;
	assign sif.raw_valid = state.raw_valid;

	tcfc_format u_format (
		.core_clk (core_clk),
		.rst      (rst),
		.sif      (sif)
	);

	// ----------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------
	assign reg_rdata = state.rdata;
	assign reg_ack = state.ack;
	assign process_word = sif.word;
	assign process_valid = sif.word_valid;
	assign over_range = sif.out_of_range;
	assign watchdog_en = state.mode[tcfc_pkg::BIT_WATCHDOG];
	assign open_circuit_current_en = !state.mode[tcfc_pkg::BIT_OPEN_OFF];
	assign cold_junction_en = !state.mode[tcfc_pkg::BIT_CJ_OFF];
	assign element_type = state.mode[tcfc_pkg::EL_MSB:tcfc_pkg::EL_LSB];
	assign conversion_tick = state.tick;
	assign notch_dhz = state.notch;
endmodule
`default_nettype wire

// File: logic/tcfc_pkg.sv
package tcfc_pkg;
	// ----------------------------------------
	// register map (register address space of 64 words)
	// ----------------------------------------
	localparam logic [5:0]  ADDR_UNLOCK_KEY = 6'h1f;
	localparam logic [5:0]  ADDR_MODE_CFG   = 6'h20;
	localparam logic [5:0]  ADDR_USR_OFFSET = 6'h21;
	localparam logic [5:0]  ADDR_USR_GAIN   = 6'h22;
	localparam logic [5:0]  ADDR_FILTER     = 6'h25;
	localparam logic [15:0] UNLOCK_KEY      = 16'h1235;
	localparam logic [15:0] MODE_CFG_RESET  = 16'h1006;
	localparam logic [15:0] USR_OFFSET_RST  = 16'h0000;
	localparam logic [15:0] USR_GAIN_RST    = 16'h0100;
	localparam logic [15:0] FILTER_RESET    = 16'h0000;
	localparam logic [15:0] MFR_OFFSET      = 16'h0000;
	localparam logic [15:0] MFR_GAIN        = 16'h00a0;
	// ----------------------------------------
	// mode bits
	// ----------------------------------------
	localparam int BIT_USER_SCALE = 0;
	localparam int BIT_MFR_SCALE  = 1;
	localparam int BIT_WATCHDOG   = 2;
	localparam int BIT_SIGN_MAG   = 3;
	localparam int BIT_TAGGED     = 4;
	localparam int BIT_FILTER_EN  = 5;
	localparam int BIT_OPEN_OFF   = 6;
	localparam int BIT_CJ_OFF     = 8;
	localparam int BIT_NO_LOWER   = 10;
	localparam int GAIN_SHIFT     = 8;
	localparam int TAG_BITS       = 3;
	localparam int EL_LSB         = 12;
	localparam int EL_MSB         = 15;
	// ----------------------------------------
	// element codes
	// ----------------------------------------
	localparam logic [3:0] EL_L = 4'h0, EL_K = 4'h1, EL_J = 4'h2, EL_E = 4'h3;
	localparam logic [3:0] EL_T = 4'h4, EL_N = 4'h5, EL_U = 4'h6, EL_B = 4'h7;
	localparam logic [3:0] EL_R = 4'h8, EL_S = 4'h9;
	localparam logic [3:0] EL_MV30 = 4'hd, EL_MV60 = 4'he, EL_MV120 = 4'hf;
	// ----------------------------------------
	// filter constants and conversion times
	// ----------------------------------------
	localparam logic [15:0] FC_DEFAULT = 16'h0000;
	localparam logic [15:0] FC_100HZ   = 16'h0050;
	localparam logic [15:0] FC_50HZ    = 16'h00a0;
	localparam logic [15:0] FC_25HZ    = 16'h0140;
	localparam logic [15:0] FC_12HZ5   = 16'h0280;
	localparam int CONV_MS_25HZ  = 250;
	localparam int CONV_MS_100HZ = 65;
	localparam int CONV_MS_50HZ  = 125;
	localparam int CONV_MS_12HZ5 = 500;
	localparam int NOTCH_DHZ_25  = 250;
	localparam int NOTCH_DHZ_100 = 1000;
	localparam int NOTCH_DHZ_50  = 500;
	localparam int NOTCH_DHZ_12  = 125;
endpackage

// File: logic/tcfc_scale_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tcfc_scale_if;
	logic        [15:0] mode;
	logic signed [15:0] usr_offset;
	logic signed [15:0] usr_gain;
	logic signed [15:0] raw;
	logic               raw_valid;
	logic        [15:0] word;
	logic               word_valid;
	logic               out_of_range;
	modport regs (output mode, usr_offset, usr_gain, raw, raw_valid,
		input word, word_valid, out_of_range);
	modport fmt (input mode, usr_offset, usr_gain, raw, raw_valid,
		output word, word_valid, out_of_range);
endinterface
`default_nettype wire

// File: logic/tcfc_format.sv
`timescale 1ns/100ps
`default_nettype none
module tcfc_format (
	input  wire logic   core_clk,
	input  wire logic   rst,
	tcfc_scale_if.fmt   sif
);
	typedef struct packed {
		logic [15:0] word;
		logic        word_valid;
		logic        oor;
	} tcfc_fmt_state_t;

	tcfc_fmt_state_t state;
	tcfc_fmt_state_t next_state;

	// ----------------------------------------
	// range limits per element, in tenths of a degree or raw digits
	// ----------------------------------------
	function automatic logic signed [17:0] lo_lim(input logic [3:0] el);
		unique case (el)
			tcfc_pkg::EL_L, tcfc_pkg::EL_U: lo_lim = -18'sd250;
			tcfc_pkg::EL_B:                  lo_lim = 18'sd6000;
			tcfc_pkg::EL_R, tcfc_pkg::EL_S:  lo_lim = 18'sd0;
			tcfc_pkg::EL_MV30:               lo_lim = -18'sd30000;
			tcfc_pkg::EL_MV60:               lo_lim = -18'sd30000;
			tcfc_pkg::EL_MV120:              lo_lim = -18'sd30000;
			default:                         lo_lim = -18'sd1000;
		endcase
	endfunction

	function automatic logic signed [17:0] hi_lim(input logic [3:0] el);
		unique case (el)
			tcfc_pkg::EL_L:                  hi_lim = 18'sd9000;
			tcfc_pkg::EL_K:                  hi_lim = 18'sd13700;
			tcfc_pkg::EL_J:                  hi_lim = 18'sd12000;
			tcfc_pkg::EL_E:                  hi_lim = 18'sd10000;
			tcfc_pkg::EL_T:                  hi_lim = 18'sd4000;
			tcfc_pkg::EL_N:                  hi_lim = 18'sd13000;
			tcfc_pkg::EL_U:                  hi_lim = 18'sd6000;
			tcfc_pkg::EL_B:                  hi_lim = 18'sd18000;
			tcfc_pkg::EL_R, tcfc_pkg::EL_S:  hi_lim = 18'sd17000;
			default:                         hi_lim = 18'sd30000;
		endcase
	endfunction

	always_comb begin
		logic signed [35:0] acc;
		logic signed [17:0] val;
		logic signed [17:0] sat;
		logic        [15:0] mag;
		logic               below;
		logic               above;
		logic        [3:0]  el;
		acc = '0;
		el = sif.mode[tcfc_pkg::EL_MSB:tcfc_pkg::EL_LSB];
		val = '0;
		sat = '0;
		mag = '0;
		below = 1'b0;
		above = 1'b0;
		next_state = state;
		next_state.word_valid = sif.raw_valid;
		if (sif.raw_valid) begin
			// range check on the unscaled reading
			val = 18'(sif.raw);
			below = (val < lo_lim(el)) && !sif.mode[tcfc_pkg::BIT_NO_LOWER];
			above = val > hi_lim(el);
			next_state.oor = below || above;
			// maker stage first, user stage second
			// the whole chain stays 36 bits wide so a large user gain
			// saturates instead of wrapping
			acc = 36'(val);
			if (sif.mode[tcfc_pkg::BIT_MFR_SCALE]) begin
				acc = ((36'(signed'(tcfc_pkg::MFR_GAIN)) * acc) >>> tcfc_pkg::GAIN_SHIFT)
					+ 36'(signed'(tcfc_pkg::MFR_OFFSET));
			end
			if (sif.mode[tcfc_pkg::BIT_USER_SCALE]) begin
				acc = ((36'(sif.usr_gain) * acc) >>> tcfc_pkg::GAIN_SHIFT)
					+ 36'(sif.usr_offset);
			end
			// without any stage the reading passes through 1 digit per input step
			sat = (acc > 36'sd32767) ? 18'sd32767
				: (acc < -36'sd32767) ? -18'sd32767 : 18'(acc);
			if (sif.mode[tcfc_pkg::BIT_SIGN_MAG]) begin
				mag = (sat < 0) ? 16'(-sat) : 16'(sat);
				next_state.word = {sat < 0, mag[14:0]};
			end else begin
				next_state.word = 16'(sat);
			end
			if (sif.mode[tcfc_pkg::BIT_TAGGED]) begin
				// value sits in bits 15..3, out-of-range flag in bit 0, bits 2..1 zero
				next_state.word = {next_state.word[15], next_state.word[14:0] >> 0};
				next_state.word[tcfc_pkg::TAG_BITS-1:0] = {2'b00, below || above};
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sif.word = state.word;
	assign sif.word_valid = state.word_valid;
	assign sif.out_of_range = state.oor;
endmodule
`default_nettype wire

// File: verification/tcfc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tcfc_top_chk #(
	parameter int CLK_HZ = 100_000_000
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        reg_req,
	input wire logic        reg_write,
	input wire logic [5:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic [15:0] adc_value,
	input wire logic        adc_strobe,
	input wire logic [15:0] process_word,
	input wire logic        process_valid,
	input wire logic        over_range,
	input wire logic        watchdog_en,
	input wire logic        open_circuit_current_en,
	input wire logic        cold_junction_en,
	input wire logic [3:0]  element_type,
	input wire logic        conversion_tick,
	input wire logic [15:0] notch_dhz
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ack_after_req: assert property (reg_req |=> reg_ack)
		else $error("register access not acknowledged");
	a_ack_only_req: assert property (!reg_req |=> !reg_ack)
		else $error("acknowledge without request");
	a_rdata_held: assert property ($changed(reg_rdata) |-> reg_ack)
		else $error("read data moved between accesses");
	a_cfg_on_ack: assert property ($changed({watchdog_en, open_circuit_current_en,
		cold_junction_en, element_type}) |-> reg_ack) else $error("mode outputs moved");
	a_notch_legal: assert property (notch_dhz inside {16'h00fa, 16'h03e8, 16'h01f4, 16'h007d})
		else $error("notch value outside table");
	a_word_on_valid: assert property ($changed({process_word, over_range}) |-> process_valid)
		else $error("output word moved without valid");
	a_valid_single: assert property (process_valid |=> !process_valid [*3])
		else $error("valid pulse too long");
	a_valid_cause: assert property (process_valid |-> $past(adc_strobe, 4) && !$past(adc_strobe, 5))
		else $error("valid without strobe");
	a_tick_pulse: assert property (conversion_tick |=> !conversion_tick [*8])
		else $error("conversion tick too long");
endmodule
`default_nettype wire

// File: verification/tcfc_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcfc_adc_model (
	input  wire logic        core_clk,
	input  wire logic        go,
	input  wire logic [15:0] val,
	output var  logic [15:0] adc_value,
	output var  logic        adc_strobe
);
	logic [3:0] cnt;
	initial begin
		cnt = 4'h0;
		adc_value = 16'h0000;
		adc_strobe = 1'b0;
	end
	always @(posedge core_clk) begin
		if (go) begin
			adc_value <= val;
			cnt <= 4'h8;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			// hold time over: stale value must not look valid
			if (cnt == 4'h1) adc_value <= ~adc_value;
		end
		adc_strobe <= go || (cnt > 4'h2);
	end
endmodule
`default_nettype wire

// File: verification/thermocouple_feature_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module thermocouple_feature_config_tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_req = 1'b0;
	logic        reg_write = 1'b0;
	logic        go = 1'b0;
	logic [5:0]  reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] go_val = 16'h0000;
	logic [15:0] reg_rdata, adc_value, process_word, notch_dhz;
	logic        reg_ack, adc_strobe, process_valid, over_range, watchdog_en;
	logic        open_circuit_current_en, cold_junction_en, conversion_tick;
	logic [3:0]  element_type;
	logic [16:0] rq[$];
	logic [16:0] pq[$];
	logic [15:0] fc[5] = '{16'h0000, 16'h0050, 16'h00a0, 16'h0140, 16'h0280};
	logic [15:0] nd[5] = '{16'h00fa, 16'h03e8, 16'h01f4, 16'h00fa, 16'h007d};
	int          err_count = 0;
	int          samples_checked = 0;
	int          r, n;
	always #5 core_clk = ~core_clk;
	tcfc_top #(.CLK_HZ(10000)) i_tcfc_top (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack), .adc_value(adc_value),
		.adc_strobe(adc_strobe), .process_word(process_word), .process_valid(process_valid),
		.over_range(over_range), .watchdog_en(watchdog_en),
		.open_circuit_current_en(open_circuit_current_en), .cold_junction_en(cold_junction_en),
		.element_type(element_type), .conversion_tick(conversion_tick), .notch_dhz(notch_dhz));
	tcfc_adc_model i_tcfc_adc_model (.core_clk(core_clk), .go(go), .val(go_val),
		.adc_value(adc_value), .adc_strobe(adc_strobe));
	task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// reads note the expected data; writes note a skip marker
	task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
		rq.push_back({!w, w ? 16'h0000 : d});
		reg_req <= 1'b1;
		reg_write <= w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_req <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic smp(input logic [15:0] raw, input logic [15:0] w, input logic o);
		pq.push_back({o, w});
		go <= 1'b1;
		go_val <= raw;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (15) @(posedge core_clk);
	endtask
	function automatic logic [15:0] sc(input int v, input int g, input int o);
		return 16'(((v * g) >>> 8) + o);
	endfunction
	always @(posedge core_clk) begin
		if (reg_ack) begin
			if (rq[0][16]) cmp({1'b1, reg_rdata}, rq[0]);
			void'(rq.pop_front());
		end
		if (process_valid) begin
			cmp({over_range, process_word}, pq[0]);
			void'(pq.pop_front());
		end
	end
	task automatic finish_test;
		if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#600us;
		err_count++;
		finish_test;
	end
	initial begin
		r = $urandom(21);
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		cmp(17'({watchdog_en, element_type}), 17'h00011);
		acc(1'b0, 6'h20, 16'h1006);
		acc(1'b0, 6'h25, 16'h0000);
		acc(1'b0, 6'h1f, 16'h0000);
		acc(1'b1, 6'h20, 16'hf000);
		acc(1'b0, 6'h20, 16'h1006);
		acc(1'b1, 6'h1f, 16'h1235);
		acc(1'b0, 6'h1f, 16'h1235);
		acc(1'b1, 6'h30, 16'hffff);
		acc(1'b0, 6'h30, 16'h0000);
		acc(1'b1, 6'h20, 16'h1144);
		@(posedge core_clk);
		cmp(17'({open_circuit_current_en, cold_junction_en, watchdog_en, element_type}), 17'h11);
		acc(1'b1, 6'h21, 16'h0005);
		acc(1'b1, 6'h22, 16'h0200);
		acc(1'b0, 6'h22, 16'h0200);
		acc(1'b1, 6'h20, 16'hf000);
		n = int'($urandom_range(1999)) - 1000;
		smp(16'(n), 16'(n), 1'b0);
		acc(1'b1, 6'h20, 16'hf002);
		smp(16'd1000, sc(1000, 160, 0), 1'b0);
		acc(1'b1, 6'h20, 16'hf008);
		smp(16'hffff, 16'h8001, 1'b0);
		acc(1'b1, 6'h20, 16'hf003);
		smp(16'd1000, sc(int'(sc(1000, 160, 0)), 512, 5), 1'b0);
		acc(1'b1, 6'h20, 16'h1010);
		smp(16'd14000, 16'h36b1, 1'b1);
		smp(16'd1000, 16'h03e8, 1'b0);
		smp(16'hf830, 16'hf831, 1'b1);
		acc(1'b1, 6'h20, 16'h1410);
		smp(16'hf830, 16'hf830, 1'b0);
		acc(1'b1, 6'h20, 16'h7000);
		smp(16'd5999, 16'h176f, 1'b1);
		acc(1'b1, 6'h20, 16'hd000);
		smp(16'h7531, 16'h7531, 1'b1);
		acc(1'b1, 6'h20, 16'h1026);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 6'h25, fc[i]);
			@(posedge core_clk);
			cmp(17'(notch_dhz), 17'(nd[i]));
		end
		acc(1'b1, 6'h25, 16'h0050);
		for (r = 0; r < 3000 && conversion_tick !== 1'b1; r++) @(posedge core_clk);
		@(posedge core_clk);
		for (n = 1; n < 3000 && conversion_tick !== 1'b1; n++) @(posedge core_clk);
		cmp(17'(n), 17'd650);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		cmp(17'(notch_dhz), 17'h000fa);
		acc(1'b0, 6'h20, 16'h1006);
		acc(1'b0, 6'h1f, 16'h0000);
		finish_test;
	end
endmodule
bind tcfc_top tcfc_top_chk #(.CLK_HZ(CLK_HZ)) i_tcfc_top_chk (.core_clk(core_clk), .rst(rst),
	.reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_ack(reg_ack), .adc_value(adc_value), .adc_strobe(adc_strobe),
	.process_word(process_word), .process_valid(process_valid), .over_range(over_range),
	.watchdog_en(watchdog_en), .open_circuit_current_en(open_circuit_current_en),
	.cold_junction_en(cold_junction_en), .element_type(element_type),
	.conversion_tick(conversion_tick), .notch_dhz(notch_dhz));
`default_nettype wire
